/* verif/rxm_line_input_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rxm_line_input_checker
	import rxm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic [RXM_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [RXM_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic rx_line_clock_in,
	input wire logic rx_positive_pulse_in,
	input wire logic rx_negative_pulse_in,
	input wire logic rx_recovered_clock_out,
	input wire rxm_sample_t rx_sample,
	input wire logic [RXM_BPV_W-1:0] bpv_count
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	rxm_cfg_t cfg_r;
	logic [3:0] age_r;
	logic acc, ref_pin, pos_l, neg_l, calm, bip, unipolar_line_mode, ohm, bpv_clr;
	assign acc = avs_write && !avs_waitrequest;
	assign bpv_clr = acc && avs_address == RXM_OFS_BPV;
	assign ref_pin = ((cfg_r.liu_en || cfg_r.ref_sel) ?
		rx_recovered_clock_out : rx_line_clock_in) ^ cfg_r.clk_inv;
	assign pos_l = rx_positive_pulse_in ^ cfg_r.pos_inv;
	assign neg_l = rx_negative_pulse_in ^ cfg_r.neg_inv;
	// A fresh setting may leave a stray edge in the synchronisers.
	assign calm = age_r > 4'h8;
	assign ohm = !cfg_r.liu_en && cfg_r.ohm_mode;
	assign unipolar_line_mode = !cfg_r.liu_en && !ohm && cfg_r.line_mode == RXM_LINE_UNI;
	assign bip = !cfg_r.liu_en && !ohm && !unipolar_line_mode;
	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_r <= '0;
			age_r <= 4'h0;
		end else if (acc && avs_byteenable[0] && avs_address == RXM_OFS_CTRL) begin
			cfg_r <= avs_writedata[RXM_CTRL_W-1:0];
			age_r <= 4'h0;
		end else if (age_r != 4'hf) begin
			age_r <= age_r + 4'h1;
		end
	end
	sequence ref_edge;
		calm && !cfg_r.liu_en && $rose(ref_pin);
	endsequence
	sequence rec_still;
		$stable(rx_recovered_clock_out)[*6] ##0 (cfg_r.liu_en && calm);
	endsequence
	a_ref_strobe: assert property (ref_edge |-> ##[3:5] rx_sample.strobe)
		else $error("no strobe after reference edge");
	a_liu_ignores: assert property (rec_still |-> !rx_sample.strobe)
		else $error("strobe from line clock");
	a_pos_pulse: assert property (rx_sample.strobe && calm && bip
		|-> rx_sample.pos_pulse == $past(pos_l, 5)) else $error("bad pos");
	a_neg_pulse: assert property (rx_sample.strobe && calm && bip
		|-> rx_sample.neg_pulse == $past(neg_l, 5)) else $error("bad neg");
	a_uni_data: assert property (rx_sample.strobe && calm && unipolar_line_mode |->
		rx_sample.data_valid && rx_sample.data == $past(pos_l, 5))
		else $error("bad data");
	a_uni_viol: assert property (rx_sample.strobe && calm && unipolar_line_mode
		|-> rx_sample.violation == $past(neg_l, 5)) else $error("bad flag");
	a_ohm_mask: assert property (rx_sample.strobe && calm && ohm
		|-> rx_sample.data_valid == !$past(neg_l, 5)) else $error("bad mask");
	a_one_view: assert property (rx_sample.strobe && calm && ohm |->
		!(rx_sample.pos_pulse || rx_sample.neg_pulse || rx_sample.violation))
		else $error("mixed view");
	a_bpv_step: assert property (rx_sample.violation && !bpv_clr
		|=> bpv_count == $past(bpv_count) + 16'h1) else $error("no count");
	a_bpv_hold: assert property (!rx_sample.violation && !bpv_clr
		|=> $stable(bpv_count)) else $error("stray count");
	a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("long wait");
endmodule
bind rxm_line_input rxm_line_input_checker u_chk (
	.clock(clock), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .rx_line_clock_in(rx_line_clock_in),
	.rx_positive_pulse_in(rx_positive_pulse_in),
	.rx_negative_pulse_in(rx_negative_pulse_in),
	.rx_recovered_clock_out(rx_recovered_clock_out),
	.rx_sample(rx_sample), .bpv_count(bpv_count)
);
`default_nettype wire

/* verif/rxm_line_src.sv */
`timescale 1ns/1ps
`default_nettype none
module rxm_line_src (
	input wire logic clock,
	input wire logic run,
	input wire logic inv,
	input wire logic [7:0] pat_p,
	input wire logic [7:0] pat_n,
	output logic lclk,
	output logic pos,
	output logic neg
);
	logic [2:0] ph = 3'h0;
	logic [2:0] idx = 3'h0;
	initial begin
		lclk = 1'b0;
		pos = 1'b0;
		neg = 1'b0;
	end
	// Pins move on the edge opposite the sampling one, a half bit each side.
	always @(posedge clock) begin
		if (!run) begin
			ph <= 3'h0;
			idx <= 3'h0;
			lclk <= 1'b0;
		end else begin
			ph <= ph + 3'h1;
			lclk <= ph[2];
			if (ph == {inv, 2'h0}) begin
				pos <= pat_p[idx];
				neg <= pat_n[idx];
				idx <= idx + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rxm_pkg::*;
;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic avs_waitrequest, irq, lclk, pos, neg, line_ck, rec_ck;
	rxm_sample_t rx_sample;
	logic [15:0] bpv_count;
	logic run = 1'b0, inv = 1'b0, sel_rec = 1'b0, clr = 1'b0;
	logic [7:0] pat_p = 8'h00, pat_n = 8'h00, cap_p, cap_n, cap_d;
	int n_stb, n_val, n_mismatch = 0, cmp_count = 0;
	always #50 clock = ~clock;
	assign line_ck = sel_rec ? 1'b0 : lclk;
	assign rec_ck = sel_rec ? lclk : 1'b0;
	rxm_line_input u_rxm_line_input (.clock(clock), .srst(srst),
		.clk_en(1'b1), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_line_clock_in(line_ck),
		.rx_positive_pulse_in(pos), .rx_negative_pulse_in(neg),
		.rx_recovered_clock_out(rec_ck), .rx_sample(rx_sample),
		.bpv_count(bpv_count), .irq(irq));
	rxm_line_src u_rxm_line_src (.clock(clock), .run(run), .inv(inv),
		.pat_p(pat_p), .pat_n(pat_n), .lclk(lclk), .pos(pos), .neg(neg));
	always @(posedge clock) begin
		if (clr) begin
			n_stb <= 0;
			n_val <= 0;
		end else if (rx_sample.strobe === 1'b1) begin
			n_stb <= n_stb + 1;
			n_val <= n_val + int'(rx_sample.data_valid);
			cap_p <= {rx_sample.pos_pulse, cap_p[7:1]};
			cap_n <= {rx_sample.neg_pulse, cap_n[7:1]};
			cap_d <= {rx_sample.data, cap_d[7:1]};
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int g;
		g = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clock);
			g++;
		end while (avs_waitrequest !== 1'b0 && g < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
		if (g >= 50) chk(32'h1, 32'h0);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic cfg(input rxm_cfg_t c);
		wr(RXM_OFS_CTRL, {24'h0, c});
		inv <= c.clk_inv;
		sel_rec <= c.ref_sel;
		repeat (10) @(posedge clock);
	endtask
	task automatic send(input logic [7:0] p, input logic [7:0] n);
		pat_p <= p;
		pat_n <= n;
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		run <= 1'b1;
		repeat (64) @(posedge clock);
		run <= 1'b0;
		repeat (12) @(posedge clock);
	endtask
	task automatic t_regs;
		rd(RXM_OFS_STATUS, 32'h3, 32'h0);
		wr(5'h14, 32'hff);
		rd(5'h14, 32'hffffffff, 32'h0);
	endtask
	task automatic t_bipolar;
		rxm_cfg_t c;
		for (int i = 0; i < 3; i++) begin
			c = '0;
			c.line_mode = 2'(i);
			c.clk_inv = (i == 1);
			c.pos_inv = (i == 1);
			c.neg_inv = (i == 2);
			cfg(c);
			send(8'h96, 8'h41);
			chk(32'(n_stb), 32'h8);
			chk(32'(cap_p), 32'(8'h96 ^ {8{c.pos_inv}}));
			chk(32'(cap_n), 32'(8'h41 ^ {8{c.neg_inv}}));
		end
	endtask
	task automatic t_uni;
		rxm_cfg_t c;
		c = '0;
		c.line_mode = RXM_LINE_UNI;
		c.pos_inv = 1'b1;
		rd(RXM_OFS_IRQ_STAT, 32'h8, 32'h8);
		cfg(c);
		wr(RXM_OFS_BPV, 32'h0);
		wr(RXM_OFS_IRQ_STAT, 32'hf);
		send(8'hb4, 8'h29);
		chk(32'(cap_d), 32'h4b);
		chk(32'(bpv_count), 32'h3);
		rd(RXM_OFS_STATUS, 32'h3, 32'h1);
		chk(32'(irq), 32'h0);
		wr(RXM_OFS_IRQ_MASK, 32'h1);
		chk(32'(irq), 32'h1);
		wr(RXM_OFS_IRQ_STAT, 32'h1);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_ohm_liu;
		rxm_cfg_t c;
		c = '0;
		c.ohm_mode = 1'b1;
		c.ref_sel = 1'b1;
		cfg(c);
		send(8'h5a, 8'h81);
		chk(32'(n_stb), 32'h8);
		chk(32'(n_val), 32'h6);
		chk(32'(bpv_count), 32'h3);
		rd(RXM_OFS_IRQ_STAT, 32'h2, 32'h2);
		rd(RXM_OFS_STATUS, 32'h3, 32'h2);
		c = '0;
		c.liu_en = 1'b1;
		cfg(c);
		send(8'hff, 8'h00);
		chk(32'(n_stb), 32'h0);
		rd(RXM_OFS_STATUS, 32'h3, 32'h3);
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		t_regs;
		t_bipolar;
		t_uni;
		t_ohm_liu;
		close_out;
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire

/* verilog/rxm_bpv_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module rxm_bpv_counter
	import rxm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic inc,
	output logic [RXM_BPV_W-1:0] count,
	output logic wrap
);
	logic [RXM_BPV_W-1:0] count_r;
	logic [RXM_BPV_W-1:0] count_nxt;
	logic wrap_r;
	wire logic [RXM_BPV_W-1:0] base = clear ? RXM_BPV_RESET : count_r;
	wire logic at_max = &count_r;

	// An increment in the clearing cycle is kept, so no violation is lost.
	assign count_nxt = inc ? base + 1'b1 : base;

	always_ff @(posedge clock) begin
		if (srst) begin
			count_r <= RXM_BPV_RESET;
			wrap_r <= 1'b0;
		end else if (clk_en) begin
			count_r <= count_nxt;
			wrap_r <= inc & ~clear & at_max;
		end
	end

	assign count = count_r;
	assign wrap = wrap_r;
endmodule
`default_nettype wire

/* verilog/rxm_line_input.sv */
`timescale 1ns/1ps
`default_nettype none
module rxm_line_input
	import rxm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [RXM_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [RXM_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [RXM_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_line_clock_in,
	input wire logic rx_positive_pulse_in,
	input wire logic rx_negative_pulse_in,
	input wire logic rx_recovered_clock_out,
	output var rxm_sample_t rx_sample,
	output logic [RXM_BPV_W-1:0] bpv_count,
	output logic irq
);
	// Configuration and status state.
	rxm_cfg_t cfg_r;
	rxm_cfg_t cfg_nxt;
	logic [RXM_IRQ_W-1:0] irq_stat_r;
	logic [RXM_IRQ_W-1:0] irq_stat_nxt;
	logic [RXM_IRQ_W-1:0] irq_mask_r;
	logic [RXM_IRQ_W-1:0] irq_mask_nxt;
	logic ack_r;
	logic [RXM_DATA_W-1:0] rdata_r;
	logic [RXM_DATA_W-1:0] rdata_nxt;

	// Sampling state.
	logic ref_prev_r;
	rxm_sample_t sample_r;
	rxm_sample_t sample_nxt;
	rxm_interp_t interp;

	// Synchronised pins, in order {recovered, line clock, negative, positive}.
	logic [RXM_SYNC_W-1:0] pins_async;
	logic [RXM_SYNC_W-1:0] pins_sync;
	logic [RXM_BPV_W-1:0] bpv_cnt;
	logic bpv_wrap;

	function automatic logic [1:0] interp_code(input rxm_interp_t i);
		case (i)
			RXM_INTERP_BIPOLAR: interp_code = 2'h0;
			RXM_INTERP_UNIPOLAR: interp_code = 2'h1;
			RXM_INTERP_OHM: interp_code = 2'h2;
			RXM_INTERP_LIU: interp_code = 2'h3;
			default: interp_code = 2'h0;
		endcase
	endfunction

	function automatic logic reg_hit(
		input logic [RXM_ADDR_W-1:0] addr,
		input logic [RXM_ADDR_W-1:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers. Every pin is asynchronous to the system clock.
	// ------------------------------------------------------------------
	assign pins_async = {
		rx_recovered_clock_out,
		rx_line_clock_in,
		rx_negative_pulse_in,
		rx_positive_pulse_in
	};

	rxm_sync2 u_sync (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	wire logic pos_sync = pins_sync[0];
	wire logic neg_sync = pins_sync[1];
	wire logic line_clk_sync = pins_sync[2];
	wire logic rec_clk_sync = pins_sync[3];

	// ------------------------------------------------------------------
	// Interpretation of the multiplexed pins.
	// ------------------------------------------------------------------
	wire logic mode_uni = (cfg_r.line_mode == RXM_LINE_UNI);

	// The unit enable outranks the mask framing, which outranks the line
	// code, so exactly one interpretation is ever in force.
	always_comb begin
		if (cfg_r.liu_en) begin
			interp = RXM_INTERP_LIU;
		end else if (cfg_r.ohm_mode) begin
			interp = RXM_INTERP_OHM;
		end else if (mode_uni) begin
			interp = RXM_INTERP_UNIPOLAR;
		end else begin
			interp = RXM_INTERP_BIPOLAR;
		end
	end

	// ------------------------------------------------------------------
	// Reference clock selection and edge detection.
	// ------------------------------------------------------------------
	// While the internal unit runs the line clock pin is not looked at; the
	// recovered clock then always times the port.
	wire logic use_recovered = cfg_r.liu_en | cfg_r.ref_sel;
	wire logic ref_raw = use_recovered ? rec_clk_sync : line_clk_sync;
	wire logic ref_level = ref_raw ^ cfg_r.clk_inv;

	// Inverting the clock turns its falling edge into the sampling edge.
	wire logic ref_edge = ref_level & ~ref_prev_r;

	// Data polarity is undone before any interpretation.
	wire logic pos_bit = pos_sync ^ cfg_r.pos_inv;
	wire logic neg_bit = neg_sync ^ cfg_r.neg_inv;

	always_ff @(posedge clock) begin
		if (srst) begin
			ref_prev_r <= 1'b0;
		end else if (clk_en) begin
			ref_prev_r <= ref_level;
		end
	end

	// ------------------------------------------------------------------
	// Sample decode. Data pins pass the same two stages as the clock, so
	// the bit taken at the detected edge is the one the source set up
	// before that edge.
	// ------------------------------------------------------------------
	always_comb begin
		sample_nxt = '0;
		sample_nxt.strobe = ref_edge & (interp != RXM_INTERP_LIU);
		case (interp)
			RXM_INTERP_BIPOLAR: begin
				sample_nxt.pos_pulse = ref_edge & pos_bit;
				sample_nxt.neg_pulse = ref_edge & neg_bit;
			end
			RXM_INTERP_UNIPOLAR: begin
				sample_nxt.data = pos_bit;
				sample_nxt.data_valid = ref_edge;
				sample_nxt.violation = ref_edge & neg_bit;
			end
			RXM_INTERP_OHM: begin
				sample_nxt.data = pos_bit;
				// Overhead bits are marked and not passed on.
				sample_nxt.data_valid = ref_edge & ~neg_bit;
			end
			RXM_INTERP_LIU: begin
				// Pins carry nothing while the internal unit is in use.
				sample_nxt = '0;
			end
			default: begin
				sample_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sample_r <= '0;
		end else if (clk_en) begin
			sample_r <= sample_nxt;
		end
	end

	assign rx_sample = sample_r;

	// ------------------------------------------------------------------
	// Register bus. Each access is answered on the second edge after it
	// is presented; writes take effect at that answering edge.
	// ------------------------------------------------------------------
	wire logic bus_req = avs_read | avs_write;
	wire logic wr_done = avs_write & ack_r;
	wire logic hit_ctrl = reg_hit(avs_address, RXM_OFS_CTRL);
	wire logic hit_status = reg_hit(avs_address, RXM_OFS_STATUS);
	wire logic hit_bpv = reg_hit(avs_address, RXM_OFS_BPV);
	wire logic hit_stat = reg_hit(avs_address, RXM_OFS_IRQ_STAT);
	wire logic hit_mask = reg_hit(avs_address, RXM_OFS_IRQ_MASK);
	wire logic be_low = avs_byteenable[0];
	wire logic [RXM_IRQ_W-1:0] wr_irq_bits = avs_writedata[RXM_IRQ_W-1:0];

	assign avs_waitrequest = bus_req & ~ack_r;

	always_comb begin
		rdata_nxt = '0;
		if (hit_ctrl) begin
			rdata_nxt[RXM_CTRL_W-1:0] = cfg_r;
		end else if (hit_status) begin
			rdata_nxt[1:0] = interp_code(interp);
			rdata_nxt[2] = ref_level;
			rdata_nxt[3] = pos_bit;
			rdata_nxt[4] = neg_bit;
		end else if (hit_bpv) begin
			rdata_nxt[RXM_BPV_W-1:0] = bpv_cnt;
		end else if (hit_stat) begin
			rdata_nxt[RXM_IRQ_W-1:0] = irq_stat_r;
		end else if (hit_mask) begin
			rdata_nxt[RXM_IRQ_W-1:0] = irq_mask_r;
		end
	end

	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_done & hit_ctrl & be_low) begin
			cfg_nxt = avs_writedata[RXM_CTRL_W-1:0];
		end
	end

	always_comb begin
		irq_mask_nxt = irq_mask_r;
		if (wr_done & hit_mask & be_low) begin
			irq_mask_nxt = wr_irq_bits;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ack_r <= 1'b0;
			rdata_r <= '0;
			cfg_r <= RXM_CTRL_RESET;
			irq_mask_r <= RXM_IRQ_RESET;
		end else if (clk_en) begin
			ack_r <= bus_req & ~ack_r;
			if (avs_read & ~ack_r) begin
				rdata_r <= rdata_nxt;
			end
			cfg_r <= cfg_nxt;
			irq_mask_r <= irq_mask_nxt;
		end
	end

	assign avs_readdata = rdata_r;

	// ------------------------------------------------------------------
	// Violation counter. A write of any value to its offset clears it.
	// ------------------------------------------------------------------
	wire logic bpv_clear = wr_done & hit_bpv;

	rxm_bpv_counter u_bpv (
		.clock(clock),
		.srst(srst),
		.clk_en(clk_en),
		.clear(bpv_clear),
		.inc(sample_r.violation),
		.count(bpv_cnt),
		.wrap(bpv_wrap)
	);

	assign bpv_count = bpv_cnt;

	// ------------------------------------------------------------------
	// Interrupt events, sticky until a one is written back.
	// ------------------------------------------------------------------
	logic [RXM_IRQ_W-1:0] irq_events;

	always_comb begin
		irq_events = '0;
		irq_events[RXM_IRQ_VIOL] = sample_r.violation;
		irq_events[RXM_IRQ_OVHD] = sample_r.strobe & ~sample_r.data_valid
			& (interp == RXM_INTERP_OHM);
		irq_events[RXM_IRQ_WRAP] = bpv_wrap;
		// Both pulse inputs high at once cannot come from a sane bipolar
		// receiver; it is flagged rather than silently passed on.
		irq_events[RXM_IRQ_BOTH] = sample_r.pos_pulse & sample_r.neg_pulse;
	end

	wire logic [RXM_IRQ_W-1:0] irq_clr =
		(wr_done & hit_stat & be_low) ? wr_irq_bits : RXM_IRQ_RESET;

	// A new event in the clearing cycle outranks the clear.
	assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_events;

	always_ff @(posedge clock) begin
		if (srst) begin
			irq_stat_r <= RXM_IRQ_RESET;
		end else if (clk_en) begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);
endmodule
`default_nettype wire

/* verilog/rxm_pkg.sv */
`default_nettype none
package rxm_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] RXM_OFS_CTRL = 5'h00;
	localparam logic [4:0] RXM_OFS_STATUS = 5'h04;
	localparam logic [4:0] RXM_OFS_BPV = 5'h08;
	localparam logic [4:0] RXM_OFS_IRQ_STAT = 5'h0c;
	localparam logic [4:0] RXM_OFS_IRQ_MASK = 5'h10;
	localparam int RXM_ADDR_W = 5;
	localparam int RXM_DATA_W = 32;

	// Control register field positions.
	localparam int RXM_CTRL_LIU_EN = 0;
	localparam int RXM_CTRL_MODE_LO = 1;
	localparam int RXM_CTRL_OHM = 3;
	localparam int RXM_CTRL_REF_SEL = 4;
	localparam int RXM_CTRL_CLK_INV = 5;
	localparam int RXM_CTRL_POS_INV = 6;
	localparam int RXM_CTRL_NEG_INV = 7;
	localparam int RXM_CTRL_W = 8;
	localparam logic [7:0] RXM_CTRL_RESET = 8'h00;

	// Line code field values.
	localparam logic [1:0] RXM_LINE_B3ZS = 2'h0;
	localparam logic [1:0] RXM_LINE_HDB3 = 2'h1;
	localparam logic [1:0] RXM_LINE_AMI = 2'h2;
	localparam logic [1:0] RXM_LINE_UNI = 2'h3;

	// Interrupt status bit positions.
	localparam int RXM_IRQ_VIOL = 0;
	localparam int RXM_IRQ_OVHD = 1;
	localparam int RXM_IRQ_WRAP = 2;
	localparam int RXM_IRQ_BOTH = 3;
	localparam int RXM_IRQ_W = 4;
	localparam logic [3:0] RXM_IRQ_RESET = 4'h0;

	localparam int RXM_BPV_W = 16;
	localparam logic [15:0] RXM_BPV_RESET = 16'h0000;
	localparam int RXM_SYNC_W = 4;
	localparam logic [3:0] RXM_SYNC_RESET = 4'h0;

	typedef enum {
		RXM_INTERP_BIPOLAR,
		RXM_INTERP_UNIPOLAR,
		RXM_INTERP_OHM,
		RXM_INTERP_LIU
	} rxm_interp_t;

	typedef struct packed {
		logic neg_inv;
		logic pos_inv;
		logic clk_inv;
		logic ref_sel;
		logic ohm_mode;
		logic [1:0] line_mode;
		logic liu_en;
	} rxm_cfg_t;

	typedef struct packed {
		logic strobe;
		logic pos_pulse;
		logic neg_pulse;
		logic data;
		logic data_valid;
		logic violation;
	} rxm_sample_t;
endpackage
`default_nettype wire

/* verilog/rxm_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module rxm_sync2
	import rxm_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [RXM_SYNC_W-1:0] async_in,
	output logic [RXM_SYNC_W-1:0] sync_out
);
	logic [RXM_SYNC_W-1:0] meta_r;
	logic [RXM_SYNC_W-1:0] sync_r;

	// Only the second stage is visible outside; the first may be metastable.
	always_ff @(posedge clock) begin
		if (srst) begin
			meta_r <= RXM_SYNC_RESET;
			sync_r <= RXM_SYNC_RESET;
		end else if (clk_en) begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule
`default_nettype wire
